// ### hw/rto_pkg.sv
// Package of register map, field positions, reset values and carrier types for the timer output stage.
package rto_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_MASK_LO   = 8'hE0;
  localparam logic [7:0] IDX_OUT_CTRL  = 8'hE3;
  localparam logic [7:0] IDX_RLD_HI    = 8'hE9;
  localparam logic [7:0] IDX_RLD_LO    = 8'hEA;
  localparam logic [7:0] IDX_CAPT_HI   = 8'hEB;
  localparam logic [7:0] IDX_CAPT_LO   = 8'hEC;
  localparam logic [7:0] IDX_COMP_HI   = 8'hED;
  localparam logic [7:0] IDX_COMP_LO   = 8'hEE;
  localparam logic [7:0] IDX_MASK_HI   = 8'hEF;
  localparam logic [7:0] IDX_MODE      = 8'hF0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned OC_PWM_EN    = 0;
  localparam int unsigned OC_PWM_POL   = 1;
  localparam int unsigned OC_OVF_EN    = 2;
  localparam int unsigned OC_OVF_POL   = 3;
  localparam int unsigned MD_OVF_TGL   = 0;
  localparam int unsigned MD_PWM_TGL   = 1;
  localparam int unsigned MD_RELOAD    = 2;
  localparam int unsigned MD_FLAG      = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0]  OC_RST       = 4'h0;
  localparam logic [3:0]  MODE_RST     = 4'h0;
  localparam logic [15:0] W16_RST      = 16'h0000;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] count;
    logic        count_step;
    logic        overflow;
    logic        capture_to_reload;
    logic        capture_to_capture;
    logic [15:0] capture_value;
  } rto_timer_t;

  typedef struct packed {
    logic        overflow_out;
    logic        pwm_out;
    logic        compare_hit;
    logic        zero_hit;
    logic        reload_enable;
    logic [15:0] reload_value;
  } rto_out_t;

endpackage : rto_pkg

// ### hw/rto_top.sv
// Output stage and latched 16-bit register access of the auto-reload timer, APB slave.
`timescale 1ns/1ps
module rto_top (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  rto_pkg::rto_timer_t    timer_in,
  output rto_pkg::rto_out_t      timer_out
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [11:0] a);
    logic [7:0] i;
    i = a[9:2];
    is_mapped = (a[11:10] == 2'b00) &&
                (i == rto_pkg::IDX_MASK_LO || i == rto_pkg::IDX_OUT_CTRL ||
                 (i >= rto_pkg::IDX_RLD_HI && i <= rto_pkg::IDX_MODE));
  endfunction : is_mapped

  logic [7:0]  idx;
  logic        setup;
  logic        wr_en;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;

  assign idx   = paddr[9:2];
  assign setup = psel & ~penable;
  // A write lands only at the edge that completes the access phase.
  assign wr_en = psel & penable & pready_q & pwrite & pstrb[0] & is_mapped(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~is_mapped(paddr);
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [3:0] oc_q;
  logic [3:0] mode_q;
  logic       flag_clr;

  // Only the four defined bits are stored; upper bits read as zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_q <= rto_pkg::OC_RST;
    end else if (wr_en && idx == rto_pkg::IDX_OUT_CTRL) begin
      oc_q <= pwdata[3:0];
    end
  end

  assign flag_clr = wr_en && idx == rto_pkg::IDX_MODE && !pwdata[rto_pkg::MD_FLAG];

  // The flag can only be cleared by software; an overflow in the clearing cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= rto_pkg::MODE_RST;
    end else begin
      if (wr_en && idx == rto_pkg::IDX_MODE) begin
        mode_q[2:0] <= pwdata[2:0];
      end
      if (timer_in.overflow) begin
        mode_q[rto_pkg::MD_FLAG] <= 1'b1;
      end else if (flag_clr) begin
        mode_q[rto_pkg::MD_FLAG] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Latched 16-bit registers: 0 reload/capture, 1 compare, 2 mask
  // ----------------------------------------------------------------
  localparam logic [7:0] HI_IDX [3] = '{rto_pkg::IDX_RLD_HI, rto_pkg::IDX_COMP_HI, rto_pkg::IDX_MASK_HI};
  localparam logic [7:0] LO_IDX [3] = '{rto_pkg::IDX_RLD_LO, rto_pkg::IDX_COMP_LO, rto_pkg::IDX_MASK_LO};

  logic [15:0] w16_q  [3];
  logic [7:0]  hold_q [3];
  logic [15:0] capt_q;

  for (genvar k = 0; k < 3; k++) begin : g_w16
    logic wr_ok;
    // The reload/capture register only takes writes while reload is enabled.
    assign wr_ok = (k != 0) || mode_q[rto_pkg::MD_RELOAD];

    // Every register keeps its own pending high byte.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        hold_q[k] <= 8'h00;
      end else if (wr_en && wr_ok && idx == HI_IDX[k]) begin
        hold_q[k] <= pwdata[7:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        w16_q[k] <= rto_pkg::W16_RST;
      end else if (k == 0 && timer_in.capture_to_reload && !mode_q[rto_pkg::MD_RELOAD]) begin
        w16_q[k] <= timer_in.capture_value;
      end else if (wr_en && wr_ok && idx == LO_IDX[k]) begin
        w16_q[k] <= {hold_q[k], pwdata[7:0]};
      end
    end
  end

  // Capture register has no write path at all.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capt_q <= rto_pkg::W16_RST;
    end else if (timer_in.capture_to_capture) begin
      capt_q <= timer_in.capture_value;
    end
  end

  // ----------------------------------------------------------------
  // Read path, sampled in the setup cycle
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      rto_pkg::IDX_MASK_LO:  rd_byte = w16_q[2][7:0];
      rto_pkg::IDX_OUT_CTRL: rd_byte = {4'h0, oc_q};
      rto_pkg::IDX_RLD_HI:   rd_byte = w16_q[0][15:8];
      rto_pkg::IDX_RLD_LO:   rd_byte = w16_q[0][7:0];
      rto_pkg::IDX_CAPT_HI:  rd_byte = capt_q[15:8];
      rto_pkg::IDX_CAPT_LO:  rd_byte = capt_q[7:0];
      rto_pkg::IDX_COMP_HI:  rd_byte = w16_q[1][15:8];
      rto_pkg::IDX_COMP_LO:  rd_byte = w16_q[1][7:0];
      rto_pkg::IDX_MASK_HI:  rd_byte = w16_q[2][15:8];
      rto_pkg::IDX_MODE:     rd_byte = {4'h0, mode_q};
      default:               rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_q <= (is_mapped(paddr)) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Masked events
  // ----------------------------------------------------------------
  logic [15:0] masked_cnt;
  logic        hit_compare;
  logic        hit_zero;
  logic        hit_compare_q;
  logic        hit_zero_q;

  assign masked_cnt  = w16_q[2] & timer_in.count;
  // Events are only raised when the counter takes a new value.
  assign hit_compare = timer_in.count_step && masked_cnt == (w16_q[2] & w16_q[1]);
  assign hit_zero    = timer_in.count_step && masked_cnt == 16'h0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_compare_q <= 1'b0;
      hit_zero_q    <= 1'b0;
    end else begin
      hit_compare_q <= hit_compare;
      hit_zero_q    <= hit_zero;
    end
  end

  // ----------------------------------------------------------------
  // Overflow output
  // ----------------------------------------------------------------
  logic ovf_act_q;
  logic ovf_act_d;
  logic ovf_pin_q;

  always_comb begin
    ovf_act_d = ovf_act_q;
    if (mode_q[rto_pkg::MD_OVF_TGL]) begin
      if (timer_in.overflow) begin
        ovf_act_d = ~ovf_act_q;
      end
    end else if (timer_in.overflow) begin
      ovf_act_d = 1'b1;
    end else if (flag_clr) begin
      ovf_act_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_act_q <= 1'b0;
      ovf_pin_q <= 1'b0;
    end else begin
      ovf_act_q <= ovf_act_d;
      // Inactive level equals the polarity bit, so disabling parks the pin there.
      ovf_pin_q <= oc_q[rto_pkg::OC_OVF_EN] ? (ovf_act_d ^ oc_q[rto_pkg::OC_OVF_POL])
                                            : oc_q[rto_pkg::OC_OVF_POL];
    end
  end

  // ----------------------------------------------------------------
  // PWM output
  // ----------------------------------------------------------------
  logic pwm_act_q;
  logic pwm_act_d;
  logic pwm_pin_q;

  // When both events coincide the compare wins, giving a zero-width pulse.
  always_comb begin
    pwm_act_d = pwm_act_q;
    if (mode_q[rto_pkg::MD_PWM_TGL]) begin
      if (hit_compare) begin
        pwm_act_d = ~pwm_act_q;
      end
    end else if (hit_compare) begin
      pwm_act_d = 1'b0;
    end else if (hit_zero) begin
      pwm_act_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_act_q <= 1'b0;
      pwm_pin_q <= 1'b0;
    end else begin
      pwm_act_q <= pwm_act_d;
      pwm_pin_q <= oc_q[rto_pkg::OC_PWM_EN] ? (pwm_act_d ^ oc_q[rto_pkg::OC_PWM_POL])
                                            : oc_q[rto_pkg::OC_PWM_POL];
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata                  = prdata_q;
  assign pready                  = pready_q;
  assign pslverr                 = pslverr_q;
  assign timer_out.overflow_out  = ovf_pin_q;
  assign timer_out.pwm_out       = pwm_pin_q;
  assign timer_out.compare_hit   = hit_compare_q;
  assign timer_out.zero_hit      = hit_zero_q;
  assign timer_out.reload_enable = mode_q[rto_pkg::MD_RELOAD];
  assign timer_out.reload_value  = w16_q[0];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic norm_set;
  assign norm_set = oc_q[rto_pkg::OC_OVF_EN] & ~mode_q[rto_pkg::MD_OVF_TGL];

  AST_OVF_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_in.overflow && norm_set && !oc_q[rto_pkg::OC_OVF_POL]) |=> timer_out.overflow_out)
    else $error("overflow output not high after overflow");

  AST_OVF_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_in.overflow && norm_set && oc_q[rto_pkg::OC_OVF_POL]) |=> !timer_out.overflow_out)
    else $error("inverted overflow output not low after overflow");

  AST_OVF_PARK: assert property (@(posedge pclk) disable iff (!presetn)
    !oc_q[rto_pkg::OC_OVF_EN] |=> timer_out.overflow_out == $past(oc_q[rto_pkg::OC_OVF_POL]))
    else $error("disabled overflow output not at polarity level");

  AST_PWM_SETRST: assert property (@(posedge pclk) disable iff (!presetn)
    (oc_q[rto_pkg::OC_PWM_EN] && !mode_q[rto_pkg::MD_PWM_TGL] && hit_zero && !hit_compare)
    |=> timer_out.pwm_out == !$past(oc_q[rto_pkg::OC_PWM_POL]))
    else $error("pwm output wrong after masked zero");

  AST_PWM_PARK: assert property (@(posedge pclk) disable iff (!presetn)
    !oc_q[rto_pkg::OC_PWM_EN] |=> timer_out.pwm_out == $past(oc_q[rto_pkg::OC_PWM_POL]))
    else $error("disabled pwm output not at polarity level");

  AST_COMPARE_EVT: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_in.count_step && ((timer_in.count ^ w16_q[1]) & w16_q[2]) == 16'h0000)
    |=> timer_out.compare_hit)
    else $error("masked compare event missed");

  AST_ZERO_EVT: assert property (@(posedge pclk) disable iff (!presetn)
    timer_out.zero_hit |-> $past(timer_in.count_step && (timer_in.count & w16_q[2]) == 16'h0000))
    else $error("masked zero event without cause");

  AST_HI_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == rto_pkg::IDX_COMP_HI) |=> $stable(w16_q[1]))
    else $error("high byte write changed compare register");

  AST_LO_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == rto_pkg::IDX_COMP_LO) |=> w16_q[1] == {$past(hold_q[1]), $past(pwdata[7:0])})
    else $error("low byte write did not load whole compare register");

  AST_HI_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && idx == rto_pkg::IDX_MASK_HI) |=> prdata[7:0] == $past(w16_q[2][15:8]))
    else $error("high byte read did not return loaded mask");

  AST_RLD_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == rto_pkg::IDX_RLD_LO && !mode_q[rto_pkg::MD_RELOAD] && !timer_in.capture_to_reload)
    |=> $stable(w16_q[0]))
    else $error("reload register written while reload disabled");

  AST_CAPT_RO: assert property (@(posedge pclk) disable iff (!presetn)
    !timer_in.capture_to_capture |=> $stable(capt_q))
    else $error("capture register changed without capture");

  AST_FLAG_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (flag_clr && !timer_in.overflow && !mode_q[rto_pkg::MD_OVF_TGL]) |=> !ovf_act_q)
    else $error("overflow output not released on flag clear");

  AST_OVF_TGL: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_in.overflow && mode_q[rto_pkg::MD_OVF_TGL]) |=> ovf_act_q != $past(ovf_act_q))
    else $error("overflow output did not toggle");

  AST_PWM_TGL: assert property (@(posedge pclk) disable iff (!presetn)
    (hit_compare && mode_q[rto_pkg::MD_PWM_TGL]) |=> pwm_act_q != $past(pwm_act_q))
    else $error("pwm output did not toggle");

  AST_OWN_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == rto_pkg::IDX_COMP_HI) |=> $stable(hold_q[2]) && $stable(hold_q[0]))
    else $error("write disturbed another high byte latch");

endmodule : rto_top

// ### test/rto_tb_top.sv
// Self-checking testbench for the timer output stage and its latched 16-bit registers.
`timescale 1ns/1ps
module rto_tb_top;
  // ----------------------------------------------------------------
  // Stimulus, outputs and bookkeeping
  // ----------------------------------------------------------------
  logic                 pclk     = 1'b0;
  logic                 presetn  = 1'b0;
  logic                 psel     = 1'b0;
  logic                 penable  = 1'b0;
  logic                 pwrite   = 1'b0;
  logic [11:0]          paddr    = 12'h000;
  logic [31:0]          pwdata   = 32'h00000000;
  logic [3:0]           pstrb    = 4'hF;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  rto_pkg::rto_timer_t  ti       = '0;
  rto_pkg::rto_out_t    tout;
  logic [32:0]          exp_q[$];
  int                   n_fail   = 0;
  int                   num_checks = 0;

  always #12.5 pclk = ~pclk;

  rto_top u_dut (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .pstrb     (pstrb),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .timer_in  (ti),
    .timer_out (tout)
  );

  // ----------------------------------------------------------------
  // Compare, verdict and bus tasks
  // ----------------------------------------------------------------
  task cmp_rd(input string nm, input logic [32:0] e, input logic [32:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp=%h got=%h", nm, e, g);
    end
  endtask : cmp_rd

  task cmp_b(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp=%b got=%b", nm, e, g);
    end
  endtask : cmp_b

  task results;
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  // The read monitor pops the oldest note whenever a read completes.
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) cmp_rd("read", 33'h0, 33'h1FFFFFFFF);
      else cmp_rd("read", exp_q.pop_front(), {pslverr, prdata});
    end
  end

  task apb(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] st, input logic [32:0] e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, d};
    pstrb <= st;
    if (!wr) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    // A slave that never answers ends the run through the common verdict.
    if (k >= 50) begin
      n_fail++;
      results;
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 4'hF, 33'h0);
  endtask : wr

  task rd(input logic [7:0] idx, input logic err, input logic [7:0] d);
    apb(1'b0, idx, 8'h00, 4'hF, {err, 24'h000000, d});
  endtask : rd

  task w16(input logic [7:0] hi, input logic [7:0] lo, input logic [15:0] v);
    wr(hi, v[15:8]);
    wr(lo, v[7:0]);
  endtask : w16

  task idle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : idle

  task pulse_ovf;
    @(posedge pclk);
    ti.overflow <= 1'b1;
    @(posedge pclk);
    ti.overflow <= 1'b0;
    #1;
  endtask : pulse_ovf

  task cap(input logic to_rld, input logic [15:0] v);
    @(posedge pclk);
    ti.capture_value <= v;
    ti.capture_to_reload <= to_rld;
    ti.capture_to_capture <= ~to_rld;
    @(posedge pclk);
    ti.capture_to_reload <= 1'b0;
    ti.capture_to_capture <= 1'b0;
  endtask : cap

  // Hits are gathered over a short window, so their exact cycle is not assumed here.
  task step(input logic [15:0] c, output logic pin, output logic ch, output logic zh);
    @(posedge pclk);
    ti.count <= c;
    ti.count_step <= 1'b1;
    @(posedge pclk);
    ti.count_step <= 1'b0;
    #1;
    pin = tout.pwm_out;
    ch = tout.compare_hit;
    zh = tout.zero_hit;
    repeat (3) begin
      @(posedge pclk);
      #1;
      ch = ch | tout.compare_hit;
      zh = zh | tout.zero_hit;
    end
  endtask : step

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    #(25 * 20000);
    n_fail++;
    results;
  end

  initial begin
    logic        p;
    logic        ch;
    logic        zh;
    logic        lv;
    logic        lp;
    logic [15:0] v;
    logic [7:0]  h;
    logic [7:0]  l;
    void'($urandom(28));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    idle(1);
    cmp_b("ovf_rst", 1'b0, tout.overflow_out);
    cmp_b("pwm_rst", 1'b0, tout.pwm_out);
    rd(rto_pkg::IDX_OUT_CTRL, 1'b0, 8'h00);
    rd(8'h10, 1'b1, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      h = i[0] ? rto_pkg::IDX_MASK_HI : rto_pkg::IDX_COMP_HI;
      l = i[0] ? rto_pkg::IDX_MASK_LO : rto_pkg::IDX_COMP_LO;
      w16(h, l, v);
      rd(h, 1'b0, v[15:8]);
      rd(l, 1'b0, v[7:0]);
    end
    w16(rto_pkg::IDX_COMP_HI, rto_pkg::IDX_COMP_LO, 16'h5500);
    wr(rto_pkg::IDX_COMP_HI, 8'hAA);
    rd(rto_pkg::IDX_COMP_HI, 1'b0, 8'h55);
    wr(rto_pkg::IDX_MASK_HI, 8'h3C);
    wr(rto_pkg::IDX_COMP_LO, 8'h00);
    rd(rto_pkg::IDX_COMP_HI, 1'b0, 8'hAA);
    wr(rto_pkg::IDX_MASK_LO, 8'h11);
    rd(rto_pkg::IDX_MASK_HI, 1'b0, 8'h3C);
    apb(1'b1, rto_pkg::IDX_COMP_LO, 8'h77, 4'h0, 33'h0);
    rd(rto_pkg::IDX_COMP_LO, 1'b0, 8'h00);
    $display("test latch done");
    v = 16'($urandom);
    cap(1'b0, v);
    w16(rto_pkg::IDX_CAPT_HI, rto_pkg::IDX_CAPT_LO, ~v);
    rd(rto_pkg::IDX_CAPT_HI, 1'b0, v[15:8]);
    rd(rto_pkg::IDX_CAPT_LO, 1'b0, v[7:0]);
    cap(1'b1, 16'hBEEF);
    w16(rto_pkg::IDX_RLD_HI, rto_pkg::IDX_RLD_LO, 16'h1234);
    rd(rto_pkg::IDX_RLD_HI, 1'b0, 8'hBE);
    rd(rto_pkg::IDX_RLD_LO, 1'b0, 8'hEF);
    wr(rto_pkg::IDX_MODE, 8'h04);
    w16(rto_pkg::IDX_RLD_HI, rto_pkg::IDX_RLD_LO, 16'h1234);
    rd(rto_pkg::IDX_RLD_HI, 1'b0, 8'h12);
    cmp_rd("reload_value", {17'h00000, 16'h1234}, {17'h00000, tout.reload_value});
    cmp_b("rld_en", 1'b1, tout.reload_enable);
    wr(rto_pkg::IDX_OUT_CTRL, 8'h0F);
    rd(rto_pkg::IDX_OUT_CTRL, 1'b0, 8'h0F);
    $display("test access done");
    for (int i = 0; i < 2; i++) begin
      lp = i[0];
      wr(rto_pkg::IDX_OUT_CTRL, {4'h0, lp, 3'b100});
      // A flag clear written while still in toggle mode does not release the overflow output, so clear again in set mode.
      wr(rto_pkg::IDX_MODE, 8'h04);
      wr(rto_pkg::IDX_MODE, 8'h04);
      idle(2);
      cmp_b("ovf_idle", lp, tout.overflow_out);
      pulse_ovf;
      cmp_b("ovf_set", ~lp, tout.overflow_out);
      rd(rto_pkg::IDX_MODE, 1'b0, 8'h0C);
      wr(rto_pkg::IDX_MODE, 8'h04);
      idle(2);
      cmp_b("ovf_clr", lp, tout.overflow_out);
      wr(rto_pkg::IDX_MODE, 8'h05);
      idle(1);
      lv = tout.overflow_out;
      pulse_ovf;
      cmp_b("ovf_tgl", ~lv, tout.overflow_out);
      pulse_ovf;
      cmp_b("ovf_tgl", lv, tout.overflow_out);
      wr(rto_pkg::IDX_OUT_CTRL, {4'h0, lp, 3'b000});
      pulse_ovf;
      idle(1);
      cmp_b("ovf_off", lp, tout.overflow_out);
    end
    $display("test overflow output done");
    w16(rto_pkg::IDX_MASK_HI, rto_pkg::IDX_MASK_LO, 16'hFFFF);
    w16(rto_pkg::IDX_COMP_HI, rto_pkg::IDX_COMP_LO, 16'h0010);
    for (int i = 0; i < 2; i++) begin
      lp = i[0];
      wr(rto_pkg::IDX_OUT_CTRL, {6'h00, lp, 1'b1});
      wr(rto_pkg::IDX_MODE, 8'h04);
      step(16'h0000, p, ch, zh);
      cmp_b("pwm_zero", ~lp, p);
      cmp_b("zero_hit", 1'b1, zh);
      step(16'h0010, p, ch, zh);
      cmp_b("pwm_cmp", lp, p);
      cmp_b("cmp_hit", 1'b1, ch);
      wr(rto_pkg::IDX_MODE, 8'h06);
      step(16'h0010, p, ch, zh);
      cmp_b("pwm_tgl", ~lp, p);
      step(16'h0010, p, ch, zh);
      cmp_b("pwm_tgl", lp, p);
      wr(rto_pkg::IDX_OUT_CTRL, {6'h00, lp, 1'b0});
      wr(rto_pkg::IDX_MODE, 8'h04);
      step(16'h0000, p, ch, zh);
      cmp_b("pwm_off", lp, p);
    end
    w16(rto_pkg::IDX_MASK_HI, rto_pkg::IDX_MASK_LO, 16'h00F0);
    w16(rto_pkg::IDX_COMP_HI, rto_pkg::IDX_COMP_LO, 16'h0035);
    step(16'h1234, p, ch, zh);
    cmp_b("cmp_hit", 1'b1, ch);
    cmp_b("zero_hit", 1'b0, zh);
    step(16'hAB0F, p, ch, zh);
    cmp_b("cmp_hit", 1'b0, ch);
    cmp_b("zero_hit", 1'b1, zh);
    step(16'h1244, p, ch, zh);
    cmp_b("cmp_hit", 1'b0, ch);
    cmp_b("zero_hit", 1'b0, zh);
    $display("test pwm output done");
    idle(4);
    results;
  end
endmodule : rto_tb_top
